// file: hw/lan_host_port_params.svh
// constants and contract of the lan controller host port
`ifndef LAN_HOST_PORT_PARAMS_SVH
`define LAN_HOST_PORT_PARAMS_SVH
`define PAGE_BYTES        13'h1000
`define MAX_READ_BYTES    13'h0080
`define RX_BUF_MIN        15'h0100
`define RX_BUF_MAX        15'h4000
`define FIFO_STEP_BYTES   16'h0400
`define PKT_BUF_BYTES     16'h8000
`define JUMBO_MAX_BYTES   14'h233A
`define LINK_RATE_MBPS    11'h4E2
`endif

// file: hw/lan_host_port_pkg.sv
// types shared by the lan controller host port
package lan_host_port_pkg;
  typedef enum logic [1:0] {SPD_10, SPD_100, SPD_1000} speed_e;
  typedef enum logic [1:0] {SB_100K, SB_400K, SB_1M} sb_rate_e;
  typedef enum logic [1:0] {PWR_S0, PWR_SX, PWR_DEEP} power_e;
  typedef enum logic [2:0] {CPL_SC, CPL_UR, CPL_CRS, CPL_CA, CPL_NONE} cpl_e;
endpackage : lan_host_port_pkg

// file: hw/req_if.sv
// request carrier between the splitter and the main module
`timescale 1ns/1ps
`default_nettype none
interface req_if;
  logic        valid;
  logic        ready;
  logic [63:0] addr;
  logic [12:0] len;
  logic        last;
  modport src (output valid, output addr, output len, output last, input ready);
  modport dst (input valid, input addr, input len, input last, output ready);
endinterface : req_if
`default_nettype wire

// file: hw/req_splitter.sv
// splits a dma request into page-safe pieces, size-capped for reads only
`timescale 1ns/1ps
`default_nettype none
`include "lan_host_port_params.svh"
module req_splitter import lan_host_port_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic        is_read,
  input  wire logic [63:0] base,
  input  wire logic [15:0] total,
  output logic             busy,
  req_if.src               out
);
  logic [63:0] addr;
  logic [15:0] left;
  logic        rd;
  logic [12:0] to_page;
  logic [12:0] cap;
  logic [12:0] piece;
  always_comb begin
    to_page = `PAGE_BYTES - {1'b0, addr[11:0]};
    cap     = rd ? (`MAX_READ_BYTES - {6'h00, addr[6:0]}) : to_page;
    if (cap > to_page) begin
      cap = to_page;
    end
    piece = (left < {3'h0, cap}) ? left[12:0] : cap;
  end
  assign busy      = left != 16'h0000;
  assign out.valid = busy;
  assign out.addr  = addr;
  assign out.len   = piece;
  assign out.last  = left == {3'h0, piece};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr <= 64'h0;
      left <= 16'h0000;
      rd   <= 1'b0;
    end else if (!busy && start) begin
      addr <= base;
      left <= total;
      rd   <= is_read;
    end else if (busy && out.ready) begin
      addr <= addr + {51'h0, piece};
      left <= left - {3'h0, piece};
    end
  end
  no_cross_a: assert property (@(posedge clk) disable iff (rst)
    out.valid |-> ({1'b0, out.addr[11:0]} + out.len) <= `PAGE_BYTES)
    else $error("request crosses page");
  read_cap_a: assert property (@(posedge clk) disable iff (rst)
    (out.valid && rd) |-> ({6'h00, out.addr[6:0]} + out.len) <= `MAX_READ_BYTES)
    else $error("read exceeds cap");
endmodule : req_splitter
`default_nettype wire

// file: hw/cfg_gate.sv
// answers configuration and malformed requests
`timescale 1ns/1ps
`default_nettype none
`include "lan_host_port_params.svh"
module cfg_gate import lan_host_port_pkg::*; (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic nvm_done,
  input  wire logic req_valid,
  input  wire logic req_cfg,
  input  wire logic req_posted,
  input  wire logic req_bad,
  input  wire logic req_unsup,
  input  wire logic serr_en,
  input  wire logic ur_rep_en,
  input  wire logic ur_clear,
  output cpl_e      cpl,
  output logic      accept,
  output logic      serr,
  output logic      unsupported_req_detected
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpl    <= CPL_NONE;
      accept <= 1'b0;
      serr   <= 1'b0;
    end else begin
      cpl    <= CPL_NONE;
      accept <= 1'b0;
      serr   <= 1'b0;
      if (req_valid) begin
        if (req_cfg && !nvm_done) begin
          cpl <= CPL_CRS;
        end else if (req_unsup) begin
          cpl  <= req_posted ? CPL_NONE : CPL_UR;
          serr <= serr_en && ur_rep_en;
        end else if (req_bad) begin
          cpl  <= req_posted ? CPL_NONE : CPL_CA;
          serr <= req_posted && serr_en && ur_rep_en;
        end else begin
          accept <= 1'b1;
          cpl    <= req_posted ? CPL_NONE : CPL_SC;
        end
      end
    end
  end
  // set wins over clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      unsupported_req_detected <= 1'b0;
    end else if (req_valid && req_unsup && !(req_cfg && !nvm_done)) begin
      unsupported_req_detected <= 1'b1;
    end else if (ur_clear) begin
      unsupported_req_detected <= 1'b0;
    end
  end
  crs_a: assert property (@(posedge clk) disable iff (rst)
    (req_valid && req_cfg && !nvm_done) |=> (cpl == CPL_CRS && !accept))
    else $error("config not retried");
  ur_flag_a: assert property (@(posedge clk) disable iff (rst)
    (req_valid && req_unsup && !req_cfg) |=> unsupported_req_detected && !accept)
    else $error("unsupported flag missing");
  ca_a: assert property (@(posedge clk) disable iff (rst)
    (req_valid && req_bad && !req_unsup && !req_posted && !req_cfg) |=> cpl == CPL_CA)
    else $error("abort completion missing");
endmodule : cfg_gate
`default_nettype wire

// file: hw/lan_controller_host_port.sv
// top of the lan controller host port
`timescale 1ns/1ps
`default_nettype none
`include "lan_host_port_params.svh"
module lan_controller_host_port import lan_host_port_pkg::*; #(
  parameter int RX_QUEUES = 2
) (
  // clock and resets
  input  wire logic        CLK_IN,
  input  wire logic        RESET_IN,
  input  wire logic        SOFT_RESET_IN,
  // power and phy pins
  input  wire power_e      POWER_STATE_IN,
  input  wire logic        CTRL_ENABLE_IN,
  input  wire logic        PHY_OFF_REQ_IN,
  input  wire logic        WAKE_KEEP_IN,
  input  wire logic        WAKE_PULL_CFG_IN,
  input  wire logic        IN_N_A_IN,
  output logic             PHY_POWER_CTL_OUT,
  output logic             LAN_SLEEP_CTL_N_OUT,
  output logic             WAKE_PULLDOWN_EN_OUT,
  output logic             WAKE_EVENT_OUT,
  // link settings
  input  wire sb_rate_e    SB_RATE_IN,
  input  wire speed_e      SPEED_REQ_IN,
  input  wire logic        HALF_DUPLEX_REQ_IN,
  input  wire logic        NVM_DONE_IN,
  output sb_rate_e         SB_RATE_OUT,
  output speed_e           SPEED_OUT,
  output logic             HALF_DUPLEX_OUT,
  output logic             MGMT_ONLY_OUT,
  output logic [10:0]      LINK_RATE_MBPS_OUT,
  // buffer settings
  input  wire logic [14:0] RX_BUF_SIZE_IN,
  input  wire logic [4:0]  RX_FIFO_KB_IN,
  output logic [14:0]      RX_BUF_SIZE_OUT,
  output logic [15:0]      RX_FIFO_BYTES_OUT,
  output logic [15:0]      TX_FIFO_BYTES_OUT,
  // receive filter
  input  wire logic        FRAME_VALID_IN,
  input  wire logic [47:0] FRAME_DA_IN,
  input  wire logic [13:0] FRAME_LEN_IN,
  input  wire logic [31:0] FRAME_HASH_IN,
  input  wire logic [47:0] UNICAST_ADDR_IN,
  input  wire logic [63:0] MCAST_TABLE_IN,
  input  wire logic        BCAST_EN_IN,
  input  wire logic        PROMISC_IN,
  output logic             FRAME_ACCEPT_OUT,
  output logic             FRAME_QUEUE_OUT,
  // dma requests
  input  wire logic        DMA_START_IN,
  input  wire logic        DMA_READ_IN,
  input  wire logic [63:0] DMA_ADDR_IN,
  input  wire logic [15:0] DMA_LEN_IN,
  input  wire logic        DMA_READY_IN,
  output logic             DMA_BUSY_OUT,
  output logic             DMA_VALID_OUT,
  output logic [63:0]      DMA_ADDR_OUT,
  output logic [12:0]      DMA_LEN_OUT,
  output logic             DMA_LAST_OUT,
  // incoming requests
  input  wire logic        REQ_VALID_IN,
  input  wire logic        REQ_CFG_IN,
  input  wire logic        REQ_POSTED_IN,
  input  wire logic        REQ_BAD_IN,
  input  wire logic        REQ_UNSUP_IN,
  input  wire logic        SERR_EN_IN,
  input  wire logic        UR_REPORT_EN_IN,
  input  wire logic        UR_CLEAR_IN,
  output cpl_e             CPL_OUT,
  output logic             REQ_ACCEPT_OUT,
  output logic             SERR_OUT,
  output logic             UR_DETECTED_OUT
);
  logic   soft_rst;
  logic   in_s0;
  logic   sleep_deasserted;
  logic   frame_ok;
  logic   mc_hit;
  speed_e next_speed;
  logic [14:0] next_buf;
  logic [4:0]  fifo_kb;
  req_if  rq ();

  // soft reset clears the datapath; config space stays on RESET_IN
  assign soft_rst = RESET_IN | SOFT_RESET_IN;
  assign in_s0    = POWER_STATE_IN == PWR_S0;

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      LAN_SLEEP_CTL_N_OUT <= 1'b0;
    end else if (!CTRL_ENABLE_IN) begin
      LAN_SLEEP_CTL_N_OUT <= 1'b0;
    end else if (in_s0) begin
      LAN_SLEEP_CTL_N_OUT <= 1'b1;
    end else begin
      LAN_SLEEP_CTL_N_OUT <= WAKE_KEEP_IN;
    end
  end
  assign sleep_deasserted = LAN_SLEEP_CTL_N_OUT;

  // in s0, driving low needs sleep deasserted; outside s0 it is driven low even while sleep is asserted
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      PHY_POWER_CTL_OUT <= 1'b0;
    end else if (!in_s0) begin
      PHY_POWER_CTL_OUT <= 1'b0;
    end else begin
      PHY_POWER_CTL_OUT <= !(PHY_OFF_REQ_IN && sleep_deasserted);
    end
  end

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      WAKE_PULLDOWN_EN_OUT <= 1'b0;
      WAKE_EVENT_OUT       <= 1'b0;
    end else begin
      WAKE_PULLDOWN_EN_OUT <= (POWER_STATE_IN == PWR_DEEP) && !WAKE_PULL_CFG_IN;
      WAKE_EVENT_OUT       <= !IN_N_A_IN && !in_s0;
    end
  end

  always_comb begin
    next_speed = SPEED_REQ_IN;
    if (!in_s0 && SPEED_REQ_IN == SPD_1000) begin
      next_speed = SPD_100;
    end
    next_buf = RX_BUF_SIZE_IN;
    if (RX_BUF_SIZE_IN < `RX_BUF_MIN) begin
      next_buf = `RX_BUF_MIN;
    end else if (RX_BUF_SIZE_IN > `RX_BUF_MAX) begin
      next_buf = `RX_BUF_MAX;
    end
    fifo_kb = (RX_FIFO_KB_IN > 5'h1F) ? 5'h1F : RX_FIFO_KB_IN;
  end

  always_ff @(posedge CLK_IN or posedge soft_rst) begin
    if (soft_rst) begin
      SPEED_OUT         <= SPD_10;
      HALF_DUPLEX_OUT   <= 1'b0;
      SB_RATE_OUT       <= SB_100K;
      MGMT_ONLY_OUT     <= 1'b0;
      RX_BUF_SIZE_OUT   <= `RX_BUF_MIN;
      RX_FIFO_BYTES_OUT <= 16'h4000;
      TX_FIFO_BYTES_OUT <= 16'h4000;
    end else begin
      SPEED_OUT         <= next_speed;
      HALF_DUPLEX_OUT   <= HALF_DUPLEX_REQ_IN && next_speed != SPD_1000;
      SB_RATE_OUT       <= SB_RATE_IN;
      MGMT_ONLY_OUT     <= !in_s0;
      RX_BUF_SIZE_OUT   <= next_buf;
      RX_FIFO_BYTES_OUT <= {1'b0, fifo_kb, 10'h000};
      TX_FIFO_BYTES_OUT <= `PKT_BUF_BYTES - {1'b0, fifo_kb, 10'h000};
    end
  end
  // fixed rate; phy presence is never probed, the nvm loads the port
  assign LINK_RATE_MBPS_OUT = `LINK_RATE_MBPS;

  always_comb begin
    mc_hit   = FRAME_DA_IN[40] && MCAST_TABLE_IN[FRAME_DA_IN[47:42]];
    frame_ok = PROMISC_IN
             || (FRAME_DA_IN == UNICAST_ADDR_IN)
             || (BCAST_EN_IN && FRAME_DA_IN == 48'hFFFFFFFFFFFF)
             || (mc_hit && FRAME_DA_IN != 48'hFFFFFFFFFFFF);
  end

  always_ff @(posedge CLK_IN or posedge soft_rst) begin
    if (soft_rst) begin
      FRAME_ACCEPT_OUT <= 1'b0;
      FRAME_QUEUE_OUT  <= 1'b0;
    end else begin
      FRAME_ACCEPT_OUT <= FRAME_VALID_IN && frame_ok && FRAME_LEN_IN <= `JUMBO_MAX_BYTES;
      FRAME_QUEUE_OUT  <= FRAME_HASH_IN[0] && RX_QUEUES > 1;
    end
  end

  req_splitter u_split (
    .clk     (CLK_IN),
    .rst     (soft_rst),
    .start   (DMA_START_IN),
    .is_read (DMA_READ_IN),
    .base    (DMA_ADDR_IN),
    .total   (DMA_LEN_IN),
    .busy    (DMA_BUSY_OUT),
    .out     (rq.src)
  );
  assign rq.ready      = DMA_READY_IN;
  assign DMA_VALID_OUT = rq.valid;
  assign DMA_ADDR_OUT  = rq.addr;
  assign DMA_LEN_OUT   = rq.len;
  assign DMA_LAST_OUT  = rq.last;

  // error flags live in config space, so RESET_IN clears them, not SOFT_RESET_IN; UR_CLEAR_IN also clears the UR flag
  cfg_gate u_gate (
    .clk                      (CLK_IN),
    .rst                      (RESET_IN),
    .nvm_done                 (NVM_DONE_IN),
    .req_valid                (REQ_VALID_IN),
    .req_cfg                  (REQ_CFG_IN),
    .req_posted               (REQ_POSTED_IN),
    .req_bad                  (REQ_BAD_IN),
    .req_unsup                (REQ_UNSUP_IN),
    .serr_en                  (SERR_EN_IN),
    .ur_rep_en                (UR_REPORT_EN_IN),
    .ur_clear                 (UR_CLEAR_IN),
    .cpl                      (CPL_OUT),
    .accept                   (REQ_ACCEPT_OUT),
    .serr                     (SERR_OUT),
    .unsupported_req_detected (UR_DETECTED_OUT)
  );

  phy_low_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    !in_s0 |=> !PHY_POWER_CTL_OUT)
    else $error("phy power high in sleep");
  sleep_s0_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (in_s0 && CTRL_ENABLE_IN) |=> LAN_SLEEP_CTL_N_OUT)
    else $error("sleep control asserted in s0");
  pc_gate_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    ($fell(PHY_POWER_CTL_OUT) && in_s0) |-> $past(LAN_SLEEP_CTL_N_OUT))
    else $error("phy off while sleep asserted");
  pulldown_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (POWER_STATE_IN == PWR_DEEP && WAKE_PULL_CFG_IN) |=> !WAKE_PULLDOWN_EN_OUT)
    else $error("pulldown on when driven");
  gig_s0_a: assert property (@(posedge CLK_IN) disable iff (soft_rst)
    !in_s0 |=> SPEED_OUT != SPD_1000)
    else $error("gigabit outside s0");
  half_a: assert property (@(posedge CLK_IN) disable iff (soft_rst)
    HALF_DUPLEX_OUT |-> SPEED_OUT != SPD_1000)
    else $error("half duplex at gigabit");
  // registered settings follow their inputs one edge later
  buf_low_a: assert property (@(posedge CLK_IN) disable iff (soft_rst)
    (RX_BUF_SIZE_IN < `RX_BUF_MIN) |=> RX_BUF_SIZE_OUT == `RX_BUF_MIN)
    else $error("buffer size below minimum");
  buf_high_a: assert property (@(posedge CLK_IN) disable iff (soft_rst)
    (RX_BUF_SIZE_IN > `RX_BUF_MAX) |=> RX_BUF_SIZE_OUT == `RX_BUF_MAX)
    else $error("buffer size above maximum");
  buf_pass_a: assert property (@(posedge CLK_IN) disable iff (soft_rst)
    (RX_BUF_SIZE_IN >= `RX_BUF_MIN && RX_BUF_SIZE_IN <= `RX_BUF_MAX) |=> RX_BUF_SIZE_OUT == $past(RX_BUF_SIZE_IN))
    else $error("buffer size not taken");
  buf_range_a: assert property (@(posedge CLK_IN) disable iff (soft_rst)
    (RX_BUF_SIZE_OUT >= `RX_BUF_MIN) && (RX_BUF_SIZE_OUT <= `RX_BUF_MAX))
    else $error("buffer size out of range");
  fifo_step_a: assert property (@(posedge CLK_IN) disable iff (soft_rst)
    RX_FIFO_BYTES_OUT[9:0] == 10'h000)
    else $error("fifo split off step");
  fifo_prog_a: assert property (@(posedge CLK_IN) disable iff (soft_rst)
    1'b1 |=> RX_FIFO_BYTES_OUT == {1'b0, $past(RX_FIFO_KB_IN), 10'h000})
    else $error("fifo split not taken");
  fifo_sum_a: assert property (@(posedge CLK_IN) disable iff (soft_rst)
    (17'(RX_FIFO_BYTES_OUT) + 17'(TX_FIFO_BYTES_OUT)) == 17'(`PKT_BUF_BYTES))
    else $error("fifo split not whole buffer");
  sb_rate_a: assert property (@(posedge CLK_IN) disable iff (soft_rst)
    1'b1 |=> SB_RATE_OUT == $past(SB_RATE_IN))
    else $error("sideband rate not taken");
  mgmt_sx_a: assert property (@(posedge CLK_IN) disable iff (soft_rst)
    !in_s0 |=> MGMT_ONLY_OUT)
    else $error("data traffic in sleep");
  mgmt_s0_a: assert property (@(posedge CLK_IN) disable iff (soft_rst)
    in_s0 |=> !MGMT_ONLY_OUT)
    else $error("management only in s0");
  half_req_a: assert property (@(posedge CLK_IN) disable iff (soft_rst)
    (HALF_DUPLEX_REQ_IN && SPEED_REQ_IN != SPD_1000) |=> HALF_DUPLEX_OUT)
    else $error("half duplex refused at low speed");
  gig_keep_a: assert property (@(posedge CLK_IN) disable iff (soft_rst)
    (in_s0 && SPEED_REQ_IN == SPD_1000) |=> SPEED_OUT == SPD_1000)
    else $error("gigabit refused in s0");
  jumbo_a: assert property (@(posedge CLK_IN) disable iff (soft_rst)
    (FRAME_VALID_IN && FRAME_LEN_IN > `JUMBO_MAX_BYTES) |=> !FRAME_ACCEPT_OUT)
    else $error("oversize frame accepted");
  promisc_a: assert property (@(posedge CLK_IN) disable iff (soft_rst)
    (FRAME_VALID_IN && PROMISC_IN && FRAME_LEN_IN <= `JUMBO_MAX_BYTES) |=> FRAME_ACCEPT_OUT)
    else $error("promiscuous frame dropped");
  ucast_a: assert property (@(posedge CLK_IN) disable iff (soft_rst)
    (FRAME_VALID_IN && FRAME_DA_IN == UNICAST_ADDR_IN && FRAME_LEN_IN <= `JUMBO_MAX_BYTES) |=> FRAME_ACCEPT_OUT)
    else $error("unicast frame dropped");
  bcast_a: assert property (@(posedge CLK_IN) disable iff (soft_rst)
    (FRAME_VALID_IN && !PROMISC_IN && !BCAST_EN_IN && FRAME_DA_IN == 48'hFFFFFFFFFFFF
     && UNICAST_ADDR_IN != 48'hFFFFFFFFFFFF) |=> !FRAME_ACCEPT_OUT)
    else $error("broadcast accepted while off");
  no_frame_a: assert property (@(posedge CLK_IN) disable iff (soft_rst)
    !FRAME_VALID_IN |=> !FRAME_ACCEPT_OUT)
    else $error("accept without frame");
  queue_hi_a: assert property (@(posedge CLK_IN) disable iff (soft_rst)
    (FRAME_HASH_IN[0] && RX_QUEUES > 1) |=> FRAME_QUEUE_OUT)
    else $error("hash not on second queue");
  queue_lo_a: assert property (@(posedge CLK_IN) disable iff (soft_rst)
    !FRAME_HASH_IN[0] |=> !FRAME_QUEUE_OUT)
    else $error("hash not on first queue");
  sleep_off_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    !CTRL_ENABLE_IN |=> !LAN_SLEEP_CTL_N_OUT)
    else $error("sleep control high while disabled");
  sleep_keep_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (CTRL_ENABLE_IN && !in_s0) |=> LAN_SLEEP_CTL_N_OUT == $past(WAKE_KEEP_IN))
    else $error("sleep control ignores wake state");
  pulldown_on_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (POWER_STATE_IN == PWR_DEEP && !WAKE_PULL_CFG_IN) |=> WAKE_PULLDOWN_EN_OUT)
    else $error("pulldown off when undriven");
  pulldown_off_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (POWER_STATE_IN != PWR_DEEP) |=> !WAKE_PULLDOWN_EN_OUT)
    else $error("pulldown on outside deep sleep");
  phy_on_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (in_s0 && !PHY_OFF_REQ_IN) |=> PHY_POWER_CTL_OUT)
    else $error("phy off without request");
  wake_evt_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    (!IN_N_A_IN && !in_s0) |=> WAKE_EVENT_OUT)
    else $error("wake input missed");
  wake_s0_a: assert property (@(posedge CLK_IN) disable iff (RESET_IN)
    in_s0 |=> !WAKE_EVENT_OUT)
    else $error("wake event in s0");
endmodule : lan_controller_host_port
`default_nettype wire

// file: testbench/host_mem_model.sv
// host memory side of the dma request handshake
`timescale 1ns/1ps
`default_nettype none
module host_mem_model (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // pacing
  input  wire logic slow_in,
  // handshake
  output logic      ready_out
);
  int          seed = 32'h10C0709F;
  logic [31:0] r;
  // random stalls catch pieces that move before they are taken
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ready_out <= 1'h0;
    end else begin
      r = $random(seed);
      ready_out <= #1 slow_in ? r[1:0] == 2'h0 : r[1:0] != 2'h0;
    end
  end
endmodule : host_mem_model
`default_nettype wire

// file: testbench/lan_controller_host_port_tb.sv
// self-checking bench for the lan controller host port
`timescale 1ns/1ps
`default_nettype none
`include "lan_host_port_params.svh"
module lan_controller_host_port_tb import lan_host_port_pkg::*; ;
  power_e      POWER_STATE_IN = PWR_S0;
  sb_rate_e    SB_RATE_IN = SB_100K, SB_RATE_OUT;
  speed_e      SPEED_REQ_IN = SPD_10, SPEED_OUT, sp;
  cpl_e        CPL_OUT;
  logic        CLK_IN = 1'h0, RESET_IN = 1'h1, SOFT_RESET_IN = 1'h0, CTRL_ENABLE_IN = 1'h1, PHY_OFF_REQ_IN = 1'h0;
  logic        WAKE_KEEP_IN = 1'h0, WAKE_PULL_CFG_IN = 1'h0, IN_N_A_IN = 1'h1, HALF_DUPLEX_REQ_IN = 1'h0;
  logic        NVM_DONE_IN = 1'h0, FRAME_VALID_IN = 1'h0, BCAST_EN_IN = 1'h0, PROMISC_IN = 1'h0;
  logic        DMA_START_IN = 1'h0, DMA_READ_IN = 1'h0, REQ_VALID_IN = 1'h0, REQ_CFG_IN = 1'h0;
  logic        REQ_POSTED_IN = 1'h0, REQ_BAD_IN = 1'h0, REQ_UNSUP_IN = 1'h0, SERR_EN_IN = 1'h0;
  logic        UR_REPORT_EN_IN = 1'h0, UR_CLEAR_IN = 1'h0, DMA_READY_IN, slow = 1'h0, crs, ur = 1'h0;
  logic [14:0] RX_BUF_SIZE_IN = 15'h0000, RX_BUF_SIZE_OUT;
  logic [4:0]  RX_FIFO_KB_IN = 5'h00;
  logic [47:0] FRAME_DA_IN = 48'h0, UNICAST_ADDR_IN = 48'h0211_2233_4455;
  logic [13:0] FRAME_LEN_IN = 14'h0000;
  logic [31:0] FRAME_HASH_IN = 32'h0, r;
  logic [63:0] MCAST_TABLE_IN = 64'h0000_0400_0000_0000, DMA_ADDR_IN = 64'h0, DMA_ADDR_OUT;
  logic [15:0] DMA_LEN_IN = 16'h0000, RX_FIFO_BYTES_OUT, TX_FIFO_BYTES_OUT;
  logic [12:0] DMA_LEN_OUT;
  logic [10:0] LINK_RATE_MBPS_OUT;
  logic        PHY_POWER_CTL_OUT, LAN_SLEEP_CTL_N_OUT, WAKE_PULLDOWN_EN_OUT, WAKE_EVENT_OUT, HALF_DUPLEX_OUT;
  logic        MGMT_ONLY_OUT, FRAME_ACCEPT_OUT, FRAME_QUEUE_OUT, DMA_BUSY_OUT, DMA_VALID_OUT, DMA_LAST_OUT;
  logic        REQ_ACCEPT_OUT, SERR_OUT, UR_DETECTED_OUT;
  int          errors = 0, tests_run = 0, seed = 32'h10C0709F, n;
  longint unsigned qa[$];
  int          ql[$];

  lan_controller_host_port #(.RX_QUEUES(2)) dut (.*);
  host_mem_model host (.clk_in(CLK_IN), .rst_in(RESET_IN), .slow_in(slow), .ready_out(DMA_READY_IN));

  always #2.5 CLK_IN = ~CLK_IN;

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int k = 1);
    repeat (k) @(posedge CLK_IN);
    #1;
  endtask : tick

  task automatic wrap_up;
    if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // valid stays high between calls so back-to-back frames never double-drive it
  task automatic frame(input logic [47:0] da, input logic [13:0] len, input logic exp);
    FRAME_DA_IN = da;
    FRAME_LEN_IN = len;
    FRAME_HASH_IN = $random(seed);
    FRAME_VALID_IN = 1'h1;
    tick();
    check(FRAME_ACCEPT_OUT, exp);
    if (exp) check(FRAME_QUEUE_OUT, FRAME_HASH_IN[0]);
  endtask : frame

  task automatic dma(input logic [63:0] a, input int len, input logic rd);
    longint unsigned x;
    int rem, lim;
    x = a;
    rem = len;
    while (rem > 0) begin
      lim = int'(`PAGE_BYTES - x % `PAGE_BYTES);
      if (rd && lim > int'(`MAX_READ_BYTES - x % `MAX_READ_BYTES)) lim = int'(`MAX_READ_BYTES - x % `MAX_READ_BYTES);
      if (rem < lim) lim = rem;
      qa.push_back(x);
      ql.push_back(lim);
      x += lim;
      rem -= lim;
    end
    DMA_ADDR_IN = a;
    DMA_LEN_IN = 16'(len);
    DMA_READ_IN = rd;
    DMA_START_IN = 1'h1;
    // a second start while busy must be ignored
    tick(slow ? 2 : 1);
    DMA_START_IN = 1'h0;
    for (n = 0; n < 4000 && DMA_BUSY_OUT !== 1'h0; n++) tick();
    if (n == 4000) begin
      errors++;
      wrap_up();
    end
    check(qa.size(), 0);
  endtask : dma

  always @(negedge CLK_IN) begin
    if (!RESET_IN && DMA_VALID_OUT === 1'h1 && DMA_READY_IN === 1'h1) begin
      if (qa.size() == 0) check(1'h1, 1'h0);
      else begin
        check(DMA_ADDR_OUT, qa[0]);
        check({DMA_LAST_OUT, DMA_LEN_OUT}, {ql.size() == 1, 13'(ql[0])});
        void'(qa.pop_front());
        void'(ql.pop_front());
      end
    end
  end

  initial begin
    tick(5);
    check(PHY_POWER_CTL_OUT, 1'h0);
    check(LAN_SLEEP_CTL_N_OUT, 1'h0);
    tick();
    RESET_IN = 1'h0;
    check(PHY_POWER_CTL_OUT, 1'h0);
    check(LAN_SLEEP_CTL_N_OUT, 1'h0);
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      POWER_STATE_IN = power_e'(r[1:0] % 2'h3);
      SB_RATE_IN = sb_rate_e'(r[3:2] % 2'h3);
      SPEED_REQ_IN = speed_e'(r[5:4] % 2'h3);
      {CTRL_ENABLE_IN, PHY_OFF_REQ_IN, WAKE_KEEP_IN, WAKE_PULL_CFG_IN, IN_N_A_IN, HALF_DUPLEX_REQ_IN} = r[11:6];
      RX_FIFO_KB_IN = r[16:12];
      RX_BUF_SIZE_IN = 15'($random(seed));
      tick(2);
      sp = (SPEED_REQ_IN == SPD_1000 && POWER_STATE_IN != PWR_S0) ? SPD_100 : SPEED_REQ_IN;
      check(SPEED_OUT, sp);
      check(HALF_DUPLEX_OUT, HALF_DUPLEX_REQ_IN && sp != SPD_1000);
      check(SB_RATE_OUT, SB_RATE_IN);
      check(MGMT_ONLY_OUT, POWER_STATE_IN != PWR_S0);
      check(LINK_RATE_MBPS_OUT, `LINK_RATE_MBPS);
      check(RX_BUF_SIZE_OUT, RX_BUF_SIZE_IN < `RX_BUF_MIN ? `RX_BUF_MIN :
            RX_BUF_SIZE_IN > `RX_BUF_MAX ? `RX_BUF_MAX : RX_BUF_SIZE_IN);
      check(RX_FIFO_BYTES_OUT, RX_FIFO_KB_IN * `FIFO_STEP_BYTES);
      check(TX_FIFO_BYTES_OUT, `PKT_BUF_BYTES - RX_FIFO_KB_IN * `FIFO_STEP_BYTES);
      if (POWER_STATE_IN != PWR_S0) check(PHY_POWER_CTL_OUT, 1'h0);
      else check(PHY_POWER_CTL_OUT, !(CTRL_ENABLE_IN && PHY_OFF_REQ_IN));
      if (!CTRL_ENABLE_IN) check(LAN_SLEEP_CTL_N_OUT, 1'h0);
      else if (POWER_STATE_IN == PWR_S0) check(LAN_SLEEP_CTL_N_OUT, 1'h1);
      else check(LAN_SLEEP_CTL_N_OUT, WAKE_KEEP_IN);
      check(WAKE_PULLDOWN_EN_OUT, POWER_STATE_IN == PWR_DEEP && !WAKE_PULL_CFG_IN);
      check(WAKE_EVENT_OUT, !IN_N_A_IN && POWER_STATE_IN != PWR_S0);
    end
    RX_BUF_SIZE_IN = 15'h00FF;
    tick();
    check(RX_BUF_SIZE_OUT, `RX_BUF_MIN);
    frame(UNICAST_ADDR_IN, 14'h0040, 1'h1);
    frame(48'h0211_2233_4456, 14'h0040, 1'h0);
    frame(48'hAB00_5E00_0001, 14'h0040, 1'h1);
    frame(48'hFFFF_FFFF_FFFF, 14'h0040, 1'h0);
    BCAST_EN_IN = 1'h1;
    frame(48'hFFFF_FFFF_FFFF, 14'h0040, 1'h1);
    frame(UNICAST_ADDR_IN, `JUMBO_MAX_BYTES, 1'h1);
    frame(UNICAST_ADDR_IN, `JUMBO_MAX_BYTES + 14'h0001, 1'h0);
    PROMISC_IN = 1'h1;
    frame(48'h0600_0000_0007, 14'h0040, 1'h1);
    FRAME_VALID_IN = 1'h0;
    dma(64'h0000_0001_0000_0FF0, 32, 1'h0);
    for (int i = 0; i < 12; i++) begin
      slow = i[0];
      r = $random(seed);
      dma({r, 20'h00000, r[11:0]}, int'(r[25:12]) + 1, r[31]);
    end
    for (int i = 0; i < 80; i++) begin
      r = $random(seed);
      {REQ_CFG_IN, REQ_POSTED_IN, REQ_BAD_IN, REQ_UNSUP_IN, SERR_EN_IN, UR_REPORT_EN_IN, UR_CLEAR_IN} = r[6:0];
      NVM_DONE_IN = i > 20 || r[7];
      REQ_VALID_IN = 1'h1;
      crs = REQ_CFG_IN && !NVM_DONE_IN;
      tick();
      if (crs) check(CPL_OUT, CPL_CRS);
      else if (REQ_UNSUP_IN) begin
        check(CPL_OUT, REQ_POSTED_IN ? CPL_NONE : CPL_UR);
        check(SERR_OUT, SERR_EN_IN && UR_REPORT_EN_IN);
      end else if (REQ_BAD_IN) begin
        check(CPL_OUT, REQ_POSTED_IN ? CPL_NONE : CPL_CA);
        check(SERR_OUT, REQ_POSTED_IN && SERR_EN_IN && UR_REPORT_EN_IN);
      end else check(CPL_OUT, REQ_POSTED_IN ? CPL_NONE : CPL_SC);
      if (crs || !(REQ_UNSUP_IN || REQ_BAD_IN)) check(SERR_OUT, 1'h0);
      check(REQ_ACCEPT_OUT, !(crs || REQ_UNSUP_IN || REQ_BAD_IN));
      ur = (!crs && REQ_UNSUP_IN) ? 1'h1 : UR_CLEAR_IN ? 1'h0 : ur;
      check(UR_DETECTED_OUT, ur);
    end
    {REQ_CFG_IN, REQ_UNSUP_IN, UR_CLEAR_IN} = 3'h2;
    tick();
    REQ_VALID_IN = 1'h0;
    SOFT_RESET_IN = 1'h1;
    #1;
    check(SPEED_OUT, SPD_10);
    check(UR_DETECTED_OUT, 1'h1);
    tick();
    SOFT_RESET_IN = 1'h0;
    wrap_up();
  end
endmodule : lan_controller_host_port_tb
`default_nettype wire
